/* File: hw/port_pin_defines.vh */
// Register offsets, reset values and mode codes for the port pin block.
// Assumes the includer supplies the special-function register bus.
`ifndef PORT_PIN_DEFINES_VH
`define PORT_PIN_DEFINES_VH
`define ADDR_P0_MODE_LO   8'hAC
`define ADDR_P0_MODE_HI   8'hAD
`define ADDR_P1_MODE_LO   8'hAE
`define ADDR_P1_MODE_HI   8'hAF
`define ADDR_P3_LATCH     8'hB0
`define ADDR_P3_MODE_HI   8'hB4
`define RST_MODE          8'h00
`define RST_P3_LATCH      8'hFF
`define MODE_DEFAULT      2'h0
`define MODE_PUSH_PULL    2'h1
`define MODE_OPEN_DRAIN   2'h2
`define MODE_INPUT        2'h3
`define BIT_RD_STROBE     7
`define BIT_WR_STROBE     6
`define BIT_T1_IN         5
`define BIT_T0_IN         4
`define BIT_IRQ1_IN       3
`define BIT_IRQ0_IN       2
`define BIT_TX0           1
`define BIT_RX0           0
`endif

/* File: hw/pin_cell.v */
// One port pin driver: turns a two-bit mode and an output value into drive signals.
// Assumes the pad resolves pull-up, output and enable externally.
`timescale 1ns/10ps
`default_nettype none
`include "port_pin_defines.vh"
module pin_cell (
  input  wire [1:0] mode_in,       // Two-bit pin mode
  input  wire       value_in,      // Value to present on the pin
  output wire       drive_out,     // Pad output level
  output wire       drive_en_out,  // Pad output enable, high while driving
  output wire       pullup_out     // Weak pull-up enable
);
  // Default mode drives only a low; a one is held by the weak pull-up.
  assign drive_out    = value_in;
  assign drive_en_out = (mode_in == `MODE_PUSH_PULL) ||
                        (((mode_in == `MODE_DEFAULT) || (mode_in == `MODE_OPEN_DRAIN)) && !value_in);
  assign pullup_out   = (mode_in == `MODE_DEFAULT);
endmodule // pin_cell
`default_nettype wire

/* File: hw/port_pin_mode.v */
// Port 0, 1 and 3 pin mode control, port 3 latch and alternate functions.
// Assumes a single-cycle SFR bus on clk_in; pad inputs are asynchronous.
//
// Notes on behaviour
// - Port 0 pins: 00 pull-up default, 01 push-pull, 10 open-drain, 11 input.
// - Port 0 low register holds pins 0-3, high holds 4-7, highest pin on top.
// - Port 1 pins use the same mode code; pins 0-3 in the low register.
// - Port 1 high register holds pins 4-7, pin 7 in its top bits.
// - All four port 0 and port 1 mode registers reset to 00.
// - External memory selection on port 0 overrides port 0 pin modes.
// - Port 3 latch resets to FF; each bit drives its general pin.
// - Port 3 bit 7 is active-low read strobe, bit 6 active-low write strobe.
// - External memory enables both strobes regardless of latch, ignoring port 3 high modes.
// - Falling edges on port 3 bit 5 and bit 4 pulse timer 1 and 0.
// - Falling edge or low on bits 3 and 2 requests enabled external interrupts.
// - Serial 0 transmit pin sends data in modes 1-3, shift clock in mode 0.
// - Serial 0 receive pin takes data in modes 1-3, bidirectional in mode 0.
// - Port 3 high mode register uses same code; pins 6-7 overridden by external memory.
`timescale 1ns/10ps
`default_nettype none
`include "port_pin_defines.vh"
module port_pin_mode (
  input  wire        clk_in,               // Core clock, 100 MHz
  input  wire        rst_in,               // Asynchronous reset, active high
  input  wire [7:0]  sfr_addr_in,          // SFR address
  input  wire [7:0]  sfr_wdata_in,         // SFR write data
  input  wire        sfr_wr_in,            // SFR write strobe
  input  wire        sfr_rd_in,            // SFR read strobe
  output reg  [7:0]  sfr_rdata_out,        // SFR read data, registered
  output reg         sfr_hit_out,          // Read address belongs to this block
  input  wire        external_access_pin,  // External-access pin level, high selects external bus
  input  wire        hardware_config_reg_one_port0_ext_in,    // Config bit: port 0 on external memory bus
  input  wire        hardware_config_reg_one_port2_ext_in,    // Config bit: port 2 on external memory bus
  input  wire [7:0]  port0_data_in,        // Port 0 output latch from the core
  input  wire [7:0]  port0_bus_in,         // Port 0 value during external bus cycles
  input  wire [7:0]  port0_bus_en_in,      // Port 0 bus drive enable
  input  wire [7:0]  port1_data_in,        // Port 1 output latch from the core
  input  wire [7:0]  port0_pad_in,         // Port 0 pad levels
  input  wire [7:0]  port1_pad_in,         // Port 1 pad levels
  input  wire [7:0]  port3_pad_in,         // Port 3 pad levels
  output wire [7:0]  port0_out,            // Port 0 pad output
  output wire [7:0]  port0_oe_out,         // Port 0 pad output enable
  output wire [7:0]  port0_pu_out,         // Port 0 weak pull-up enable
  output wire [7:0]  port1_out,            // Port 1 pad output
  output wire [7:0]  port1_oe_out,         // Port 1 pad output enable
  output wire [7:0]  port1_pu_out,         // Port 1 weak pull-up enable
  output wire [7:0]  port3_out,            // Port 3 pad output
  output wire [7:0]  port3_oe_out,         // Port 3 pad output enable
  output wire [7:0]  port3_pu_out,         // Port 3 weak pull-up enable
  output reg  [7:0]  port0_pin_out,        // Synchronised port 0 pin levels
  output reg  [7:0]  port1_pin_out,        // Synchronised port 1 pin levels
  input  wire        ext_rd_strobe_n_in,   // External read strobe, active low
  input  wire        ext_wr_strobe_n_in,   // External write strobe, active low
  input  wire [1:0]  serial0_mode_in,      // Serial port 0 mode
  input  wire        serial0_tx_data_in,   // Serial 0 transmit data or shift clock
  input  wire        serial0_rx_drive_in,  // Mode 0 value driven on the receive pin
  input  wire        serial0_rx_oe_in,     // Mode 0 receive pin drive request
  input  wire        ext_irq_zero_en_in,   // External interrupt 0 enabled
  input  wire        ext_irq_one_en_in,    // External interrupt 1 enabled
  input  wire        ext_irq_zero_edge_in, // External interrupt 0 edge triggered
  input  wire        ext_irq_one_edge_in,  // External interrupt 1 edge triggered
  output reg         timer_zero_count_out, // One-cycle count pulse for timer 0
  output reg         timer_one_count_out,  // One-cycle count pulse for timer 1
  output reg         ext_irq_zero_out,     // External interrupt 0 request
  output reg         ext_irq_one_out,      // External interrupt 1 request
  output reg         serial0_rx_data_out   // Synchronised serial 0 receive data
);
  reg [7:0] port0_mode_low_q;
  reg [7:0] port0_mode_high_q;
  reg [7:0] port1_mode_low_q;
  reg [7:0] port1_mode_high_q;
  reg [7:0] port_three_mode_high_q;
  reg [7:0] port_three_latch_q;
  reg [7:0] p0_meta_q;
  reg [7:0] p1_meta_q;
  reg [7:0] p3_meta_q;
  reg [7:0] p3_sync_q;
  reg [7:0] p3_prev_q;
  reg       ext_pin_meta_q;
  reg       ext_pin_sync_q;
  wire      p0_ext;
  wire      mem_ext;
  wire [15:0] p0_modes;
  wire [15:0] p1_modes;
  wire [15:0] p3_modes;
  wire [7:0]  p3_value;
  wire [7:0]  p0_oe_cell;
  wire [7:0]  p0_drv_cell;
  wire [7:0]  p0_pu_cell;
  wire [7:0]  p3_oe_cell;
  wire [7:0]  rx_fall;

  function is_addr;
    input [7:0] addr;
    input [7:0] target;
    begin
      is_addr = (addr == target);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register writes.
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      port0_mode_low_q       <= `RST_MODE;
      port0_mode_high_q      <= `RST_MODE;
      port1_mode_low_q       <= `RST_MODE;
      port1_mode_high_q      <= `RST_MODE;
      port_three_mode_high_q <= `RST_MODE;
      port_three_latch_q     <= `RST_P3_LATCH;
    end else if (sfr_wr_in) begin
      if (is_addr(sfr_addr_in, `ADDR_P0_MODE_LO)) begin
        port0_mode_low_q <= sfr_wdata_in;
      end else if (is_addr(sfr_addr_in, `ADDR_P0_MODE_HI)) begin
        port0_mode_high_q <= sfr_wdata_in;
      end else if (is_addr(sfr_addr_in, `ADDR_P1_MODE_LO)) begin
        port1_mode_low_q <= sfr_wdata_in;
      end else if (is_addr(sfr_addr_in, `ADDR_P1_MODE_HI)) begin
        port1_mode_high_q <= sfr_wdata_in;
      end else if (is_addr(sfr_addr_in, `ADDR_P3_MODE_HI)) begin
        port_three_mode_high_q <= sfr_wdata_in;
      end else if (is_addr(sfr_addr_in, `ADDR_P3_LATCH)) begin
        port_three_latch_q <= sfr_wdata_in;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pad input synchronisers; the first stage feeds only the second.
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      p0_meta_q      <= 8'hFF;
      p1_meta_q      <= 8'hFF;
      p3_meta_q      <= 8'hFF;
      port0_pin_out  <= 8'hFF;
      port1_pin_out  <= 8'hFF;
      p3_sync_q      <= 8'hFF;
      p3_prev_q      <= 8'hFF;
      ext_pin_meta_q <= 1'b0;
      ext_pin_sync_q <= 1'b0;
    end else begin
      p0_meta_q      <= port0_pad_in;
      p1_meta_q      <= port1_pad_in;
      p3_meta_q      <= port3_pad_in;
      port0_pin_out  <= p0_meta_q;
      port1_pin_out  <= p1_meta_q;
      p3_sync_q      <= p3_meta_q;
      p3_prev_q      <= p3_sync_q;
      ext_pin_meta_q <= external_access_pin;
      ext_pin_sync_q <= ext_pin_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus selection and per-pin modes.
  assign p0_ext   = ext_pin_sync_q | hardware_config_reg_one_port0_ext_in;
  assign mem_ext  = p0_ext | hardware_config_reg_one_port2_ext_in;
  assign p0_modes = {port0_mode_high_q, port0_mode_low_q};
  assign p1_modes = {port1_mode_high_q, port1_mode_low_q};
  // Pins 0-3 of port 3 stay in the default mode here; their low mode register lives elsewhere.
  assign p3_modes = {mem_ext ? 2'b01 : port_three_mode_high_q[7:6],
                     mem_ext ? 2'b01 : port_three_mode_high_q[5:4],
                     port_three_mode_high_q[3:0], 8'h00};

  // Each latch bit drives its pin; alternate outputs pass where the latch is one, and the strobes always pass under external memory.
  assign p3_value[7] = mem_ext ? ext_rd_strobe_n_in
                               : (port_three_latch_q[7] & ext_rd_strobe_n_in);
  assign p3_value[6] = mem_ext ? ext_wr_strobe_n_in
                               : (port_three_latch_q[6] & ext_wr_strobe_n_in);
  assign p3_value[5:2] = port_three_latch_q[5:2];
  assign p3_value[1] = port_three_latch_q[1] & serial0_tx_data_in;
  assign p3_value[0] = port_three_latch_q[0] &
                       ((serial0_mode_in == 2'h0) ? (serial0_rx_drive_in | ~serial0_rx_oe_in) : 1'b1);

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_pin
      pin_cell u_p0 (
        .mode_in      (p0_modes[2*gi+1:2*gi]),
        .value_in     (port0_data_in[gi]),
        .drive_out    (p0_drv_cell[gi]),
        .drive_en_out (p0_oe_cell[gi]),
        .pullup_out   (p0_pu_cell[gi])
      );
      pin_cell u_p1 (
        .mode_in      (p1_modes[2*gi+1:2*gi]),
        .value_in     (port1_data_in[gi]),
        .drive_out    (port1_out[gi]),
        .drive_en_out (port1_oe_out[gi]),
        .pullup_out   (port1_pu_out[gi])
      );
      pin_cell u_p3 (
        .mode_in      (p3_modes[2*gi+1:2*gi]),
        .value_in     (p3_value[gi]),
        .drive_out    (port3_out[gi]),
        .drive_en_out (p3_oe_cell[gi]),
        .pullup_out   (port3_pu_out[gi])
      );
    end
  endgenerate

  // External bus owns port 0 outright while selected.
  assign port0_out    = p0_ext ? port0_bus_in    : p0_drv_cell;
  assign port0_oe_out = p0_ext ? port0_bus_en_in : p0_oe_cell;
  assign port0_pu_out = p0_ext ? 8'h00           : p0_pu_cell;
  assign port3_oe_out = p3_oe_cell;

  ////////////////////////////////////////////////////////////////////////////
  // Alternate inputs of port 3.
  assign rx_fall = p3_prev_q & ~p3_sync_q;

  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      timer_zero_count_out <= 1'b0;
      timer_one_count_out  <= 1'b0;
      ext_irq_zero_out     <= 1'b0;
      ext_irq_one_out      <= 1'b0;
      serial0_rx_data_out  <= 1'b1;
    end else begin
      timer_one_count_out  <= rx_fall[`BIT_T1_IN];
      timer_zero_count_out <= rx_fall[`BIT_T0_IN];
      ext_irq_one_out      <= ext_irq_one_en_in &
                              (ext_irq_one_edge_in ? rx_fall[`BIT_IRQ1_IN] : ~p3_sync_q[`BIT_IRQ1_IN]);
      ext_irq_zero_out     <= ext_irq_zero_en_in &
                              (ext_irq_zero_edge_in ? rx_fall[`BIT_IRQ0_IN] : ~p3_sync_q[`BIT_IRQ0_IN]);
      serial0_rx_data_out  <= p3_sync_q[`BIT_RX0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register reads; the latch address reads the synchronised port 3 pin levels, unmapped addresses read zero.
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sfr_rdata_out <= 8'h00;
      sfr_hit_out   <= 1'b0;
    end else begin
      sfr_hit_out <= 1'b0;
      if (!sfr_rd_in) begin
        sfr_rdata_out <= 8'h00;
      end else if (is_addr(sfr_addr_in, `ADDR_P0_MODE_LO)) begin
        sfr_rdata_out <= port0_mode_low_q;
        sfr_hit_out   <= 1'b1;
      end else if (is_addr(sfr_addr_in, `ADDR_P0_MODE_HI)) begin
        sfr_rdata_out <= port0_mode_high_q;
        sfr_hit_out   <= 1'b1;
      end else if (is_addr(sfr_addr_in, `ADDR_P1_MODE_LO)) begin
        sfr_rdata_out <= port1_mode_low_q;
        sfr_hit_out   <= 1'b1;
      end else if (is_addr(sfr_addr_in, `ADDR_P1_MODE_HI)) begin
        sfr_rdata_out <= port1_mode_high_q;
        sfr_hit_out   <= 1'b1;
      end else if (is_addr(sfr_addr_in, `ADDR_P3_MODE_HI)) begin
        sfr_rdata_out <= port_three_mode_high_q;
        sfr_hit_out   <= 1'b1;
      end else if (is_addr(sfr_addr_in, `ADDR_P3_LATCH)) begin
        sfr_rdata_out <= p3_sync_q;
        sfr_hit_out   <= 1'b1;
      end else begin
        sfr_rdata_out <= 8'h00;
      end
    end
  end
endmodule // port_pin_mode
`default_nettype wire

/* File: tb/port_pin_monitor.sv */
// Checker bound to the port pin block; it sees the block's ports only.
// Assumes one core clock and an asynchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
`include "port_pin_defines.vh"
module port_pin_monitor (
  input wire logic       clk_in, rst_in, sfr_wr_in, sfr_rd_in, sfr_hit_out,        // Clock, reset, bus strobes
  input wire logic [7:0] sfr_addr_in, sfr_wdata_in, sfr_rdata_out,                // Register bus
  input wire logic       hardware_config_reg_one_port0_ext_in, hardware_config_reg_one_port2_ext_in,                    // External bus selection
  input wire logic [7:0] port0_bus_en_in, port0_oe_out, port1_data_in, port1_oe_out, // Ports 0 and 1
  input wire logic [7:0] port3_pad_in, port3_out, port3_oe_out,                   // Port 3
  input wire logic       ext_rd_strobe_n_in, ext_wr_strobe_n_in, timer_one_count_out, // Strobes and timer
  input wire logic       ext_irq_one_en_in, ext_irq_one_edge_in, ext_irq_one_out  // Interrupt 1
);
  logic [7:0] sh_q [0:4];
  logic [7:0] latch_q;
  logic [7:0] rd_exp_q;
  logic       wrote_q;
  function automatic int idx(input logic [7:0] a);
    return (a == `ADDR_P3_MODE_HI) ? 4 : (a >= `ADDR_P0_MODE_LO && a <= `ADDR_P1_MODE_HI) ? int'(a[1:0]) : 7;
  endfunction
  function automatic logic [7:0] exp_oe(input logic [15:0] md, input logic [7:0] d);
    for (int i = 0; i < 8; i++) exp_oe[i] = md[2*i+:2] == `MODE_PUSH_PULL || (!md[2*i] && !d[i]);
  endfunction
  // Shadow copies follow the writes, so expectations never lean on the block's own registers.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sh_q <= '{default: `RST_MODE};
      latch_q <= `RST_P3_LATCH;
      rd_exp_q <= 8'h00;
      wrote_q <= 1'b0;
    end else begin
      rd_exp_q <= sh_q[idx(sfr_addr_in) % 5];
      if (sfr_wr_in && idx(sfr_addr_in) < 5) sh_q[idx(sfr_addr_in)] <= sfr_wdata_in;
      if (sfr_wr_in && idx(sfr_addr_in) < 5) wrote_q <= 1'b1;
      if (sfr_wr_in && sfr_addr_in == `ADDR_P3_LATCH) latch_q <= sfr_wdata_in;
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  sequence s_ext_sel; hardware_config_reg_one_port2_ext_in [*3]; endsequence
  sequence s_t1_fall; $fell(port3_pad_in[5]) ##1 !port3_pad_in[5] [*2]; endsequence
  sequence s_masked; !ext_irq_one_en_in [*3]; endsequence
  sequence s_low_on; (!port3_pad_in[3] && ext_irq_one_en_in && !ext_irq_one_edge_in) [*4]; endsequence
  property p_readback; sfr_rd_in && idx(sfr_addr_in) < 5 |=> sfr_hit_out && sfr_rdata_out == rd_exp_q; endproperty
  a_readback: assert property (p_readback) else $error("mode register read-back mismatch");
  property p_mode_reset; !wrote_q && sfr_rd_in && idx(sfr_addr_in) < 4 |=> sfr_rdata_out == `RST_MODE; endproperty
  a_mode_reset: assert property (p_mode_reset) else $error("mode register not zero after reset");
  property p_p1_oe; port1_oe_out == exp_oe({sh_q[3], sh_q[2]}, port1_data_in); endproperty
  a_p1_oe: assert property (p_p1_oe) else $error("port 1 drive enable disagrees with mode");
  property p_p0_ext; hardware_config_reg_one_port0_ext_in && $past(hardware_config_reg_one_port0_ext_in) |-> port0_oe_out == port0_bus_en_in; endproperty
  a_p0_ext: assert property (p_p0_ext) else $error("port 0 not handed to the memory bus");
  property p_strobe; s_ext_sel |-> port3_oe_out[7:6] == 2'h3 && port3_out[7:6] == {ext_rd_strobe_n_in, ext_wr_strobe_n_in};
  endproperty
  a_strobe: assert property (p_strobe) else $error("memory strobes not on port 3");
  property p_latch_pins; port3_oe_out[3:2] == ~latch_q[3:2]; endproperty
  a_latch_pins: assert property (p_latch_pins) else $error("port 3 latch not driving its pins");
  property p_t1_fall; s_t1_fall |-> ##[0:1] timer_one_count_out; endproperty
  a_t1_fall: assert property (p_t1_fall) else $error("timer 1 count pulse missing");
  property p_t1_single; $rose(timer_one_count_out) |=> $fell(timer_one_count_out); endproperty
  a_t1_single: assert property (p_t1_single) else $error("timer 1 count pulse too long");
  property p_irq_mask; s_masked |-> !ext_irq_one_out; endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("masked interrupt 1 requested");
  property p_irq_level; s_low_on |-> ext_irq_one_out; endproperty
  a_irq_level: assert property (p_irq_level) else $error("low level on interrupt 1 pin ignored");
endmodule // port_pin_monitor
bind port_pin_mode port_pin_monitor u_port_pin_monitor (.*);
`default_nettype wire

/* File: tb/port_pad_model.sv */
// Pad model for one eight-bit port: resolves the block's drive against the outside world.
// Assumes the bench enables an outside driver only where the block is not driving.
`timescale 1ns/10ps
`default_nettype none
module port_pad_model (
  input  wire logic       clk_in,      // Core clock, paces the floating pattern
  input  wire logic [7:0] drive_in,    // Block pad output
  input  wire logic [7:0] drive_en_in, // Block output enable
  input  wire logic [7:0] pull_in,     // Block weak pull-up
  input  wire logic [7:0] far_en_in,   // Outside driver enable
  input  wire logic [7:0] far_val_in,  // Outside driver level
  output var  logic [7:0] pad_out      // Resolved pad level
);
  // A pin nobody holds toggles every cycle, so a floating line never reads as a lucky constant.
  logic [7:0] float_q = 8'h55;
  always @(posedge clk_in) float_q <= ~float_q;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pad_out[i] = drive_en_in[i] ? drive_in[i] : far_en_in[i] ? far_val_in[i] : pull_in[i] ? 1'b1 : float_q[i];
    end
  end
endmodule // port_pad_model
`default_nettype wire

/* File: tb/port_pin_mode_and_alt_func_tb_top.sv */
// Self-checking bench for the port pin block with pad models on ports 0, 1 and 3.
// Assumes the block's header is on the include path and the checker binds itself.
`timescale 1ns/10ps
`default_nettype none
`include "port_pin_defines.vh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin err_total++; $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module port_pin_mode_and_alt_func_tb_top;
  logic        clk_in, rst_in, sfr_wr_in, sfr_rd_in, external_access_pin, hardware_config_reg_one_port0_ext_in, hardware_config_reg_one_port2_ext_in, pend;
  logic        ext_rd_strobe_n_in, ext_wr_strobe_n_in, serial0_tx_data_in, serial0_rx_drive_in, serial0_rx_oe_in;
  logic        ext_irq_zero_en_in, ext_irq_one_en_in, ext_irq_zero_edge_in, ext_irq_one_edge_in;
  logic [1:0]  serial0_mode_in;
  logic [7:0]  sfr_addr_in, sfr_wdata_in, port0_data_in, port0_bus_in, port0_bus_en_in, port1_data_in, fe3, fv3;
  logic [7:0]  m [0:3];
  wire  [7:0]  sfr_rdata_out, port0_out, port0_oe_out, port0_pu_out, port1_out, port1_oe_out, port1_pu_out;
  wire  [7:0]  port3_out, port3_oe_out, port3_pu_out, port0_pin_out, port1_pin_out;
  wire  [7:0]  port0_pad_in, port1_pad_in, port3_pad_in;
  wire         sfr_hit_out, timer_zero_count_out, timer_one_count_out, ext_irq_zero_out, ext_irq_one_out;
  wire         serial0_rx_data_out;
  wire  [3:0]  ev = {timer_one_count_out, timer_zero_count_out, ext_irq_one_out, ext_irq_zero_out};
  logic [31:0] seed = 32'h013A;
  logic [8:0]  exp_q [$];
  logic [8:0]  exp_e;
  int          checks = 0, err_total = 0, n;
  port_pin_mode u_port_pin_mode (.*);
  port_pad_model u_pad0 (.clk_in(clk_in), .drive_in(port0_out), .drive_en_in(port0_oe_out), .pull_in(port0_pu_out),
                         .far_en_in(8'h00), .far_val_in(8'h00), .pad_out(port0_pad_in));
  port_pad_model u_pad1 (.clk_in(clk_in), .drive_in(port1_out), .drive_en_in(port1_oe_out), .pull_in(port1_pu_out),
                         .far_en_in(8'h00), .far_val_in(8'h00), .pad_out(port1_pad_in));
  port_pad_model u_pad3 (.clk_in(clk_in), .drive_in(port3_out), .drive_en_in(port3_oe_out), .pull_in(port3_pu_out),
                         .far_en_in(fe3), .far_val_in(fv3), .pad_out(port3_pad_in));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic step(input int k);
    repeat (k) @(posedge clk_in);
    #1;
  endtask
  // One bus cycle; a read notes its expected hit and data for the watcher.
  task automatic bus(input logic w, input logic [7:0] a, input logic [8:0] e);
    {sfr_wr_in, sfr_rd_in, sfr_addr_in, sfr_wdata_in} = {w, !w, a, e[7:0]};
    if (!w) exp_q.push_back(e);
    step(1);
  endtask
  task automatic chk_port(input logic [15:0] md, input logic [7:0] d, oe, pu, o);
    logic [7:0] e_oe, e_pu, msk;
    for (int i = 0; i < 8; i++) begin
      e_oe[i] = md[2*i+:2] == `MODE_PUSH_PULL || (!md[2*i] && !d[i]);
      e_pu[i] = md[2*i+:2] == `MODE_DEFAULT;
      msk[i] = md[2*i+:2] != `MODE_PUSH_PULL;
    end
    `CHK("pin enable", e_oe, oe)
    `CHK("pin pull-up", e_pu & msk, pu & msk)
    `CHK("pin level", d & e_oe, o & e_oe)
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge clk_in) pend <= sfr_rd_in;
  always @(negedge clk_in) begin
    if (pend === 1'b1 && exp_q.size() > 0) begin
      exp_e = exp_q.pop_front();
      `CHK("sfr read", exp_e, {sfr_hit_out, sfr_rdata_out})
    end
  end
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  initial begin
    #300000;
    err_total++;
    test_done();
  end
  initial begin
    {rst_in, sfr_wr_in, sfr_rd_in, external_access_pin, hardware_config_reg_one_port0_ext_in, hardware_config_reg_one_port2_ext_in} = 6'h20;
    {ext_rd_strobe_n_in, ext_wr_strobe_n_in, serial0_tx_data_in, serial0_rx_drive_in, serial0_rx_oe_in} = 5'h1E;
    {ext_irq_zero_en_in, ext_irq_one_en_in, ext_irq_zero_edge_in, ext_irq_one_edge_in, serial0_mode_in} = 6'h0D;
    {sfr_addr_in, sfr_wdata_in, port0_data_in, port0_bus_in, port0_bus_en_in, port1_data_in} = '0;
    {fe3, fv3} = 16'h00FF;
    step(6);
    rst_in = 1'b0;
    for (int j = 0; j < 4; j++) bus(1'b0, 8'(`ADDR_P0_MODE_LO + j), {1'b1, `RST_MODE});
    bus(1'b0, `ADDR_P3_MODE_HI, {1'b1, `RST_MODE});
    bus(1'b0, `ADDR_P3_LATCH, 9'h1FF);
    bus(1'b0, 8'hA5, 9'h000);
    for (int k = 0; k < 6; k++) begin
      for (int j = 0; j < 4; j++) begin
        seed = xs(seed);
        m[j] = seed[7:0];
        bus(1'b1, 8'(`ADDR_P0_MODE_LO + j), {1'b0, m[j]});
      end
      for (int j = 0; j < 4; j++) bus(1'b0, 8'(`ADDR_P0_MODE_LO + j), {1'b1, m[j]});
      {port0_data_in, port1_data_in, sfr_wr_in, sfr_rd_in} = {seed[23:8], 2'h0};
      step(1);
      chk_port({m[1], m[0]}, port0_data_in, port0_oe_out, port0_pu_out, port0_out);
      chk_port({m[3], m[2]}, port1_data_in, port1_oe_out, port1_pu_out, port1_out);
      // Driven pins settle through the two-stage synchroniser before they read back.
      step(2);
      `CHK("port 0 pin read", port0_data_in & port0_oe_out, port0_pin_out & port0_oe_out)
      `CHK("port 1 pin read", port1_data_in & port1_oe_out, port1_pin_out & port1_oe_out)
    end
    {port0_bus_in, port0_bus_en_in, hardware_config_reg_one_port0_ext_in} = {seed[31:16], 1'b1};
    step(2);
    `CHK("bus enable", port0_bus_en_in, port0_oe_out)
    `CHK("bus data", port0_bus_in & port0_bus_en_in, port0_out & port0_bus_en_in)
    {hardware_config_reg_one_port0_ext_in, external_access_pin} = 2'h1;
    step(3);
    `CHK("bus enable by pin", port0_bus_en_in, port0_oe_out)
    external_access_pin = 1'b0;
    bus(1'b1, `ADDR_P3_MODE_HI, 9'h007);
    bus(1'b1, `ADDR_P3_LATCH, 9'h0A7);
    bus(1'b0, `ADDR_P3_MODE_HI, 9'h107);
    {sfr_wr_in, sfr_rd_in} = 2'h0;
    step(1);
    `CHK("port 3 enables", 6'h1A, port3_oe_out[7:2])
    `CHK("port 3 pins", 8'hA4, port3_pad_in & 8'hEC)
    for (int s = 0; s < 4; s++) begin
      seed = xs(seed);
      {serial0_mode_in, serial0_tx_data_in} = {2'(s), seed[0]};
      step(2);
      `CHK("transmit pin", serial0_tx_data_in, port3_pad_in[1])
    end
    {serial0_mode_in, serial0_rx_oe_in, serial0_rx_drive_in} = 4'h2;
    step(2);
    `CHK("receive pin drive", 1'b0, port3_pad_in[0])
    {serial0_mode_in, serial0_rx_oe_in, fe3[0], fv3[0]} = {2'h1, 1'b0, 1'b1, seed[1]};
    step(4);
    `CHK("receive data", seed[1], serial0_rx_data_out)
    // Pins 7 and 6 are set to input here; the memory selection must override that.
    bus(1'b1, `ADDR_P3_MODE_HI, 9'h0F7);
    {sfr_wr_in, hardware_config_reg_one_port2_ext_in} = 2'h1;
    for (int i = 0; i < 4; i++) begin
      {ext_rd_strobe_n_in, ext_wr_strobe_n_in} = 2'(i);
      step(3);
      `CHK("strobes", 2'(i), port3_pad_in[7:6])
    end
    hardware_config_reg_one_port2_ext_in = 1'b0;
    bus(1'b1, `ADDR_P3_MODE_HI, 9'h000);
    bus(1'b1, `ADDR_P3_LATCH, 9'h0FF);
    {sfr_wr_in, fe3[5:2]} = 5'h0F;
    for (int b = 2; b < 6; b++) begin
      for (int p = 0; p < 2; p++) begin
        {ext_irq_zero_en_in, ext_irq_one_en_in} = {2{p == 0}};
        step(4);
        {fv3[b], n} = {1'b0, 32'h0};
        repeat (8) begin
          step(1);
          n += ev[b-2];
        end
        `CHK("pulse count", (b > 3 || p == 0) ? 1 : 0, n)
        fv3[b] = 1'b1;
      end
    end
    {ext_irq_one_en_in, ext_irq_one_edge_in, fv3[3]} = 3'h4;
    step(6);
    `CHK("level request", 1'b1, ext_irq_one_out)
    fv3[3] = 1'b1;
    step(4);
    test_done();
  end
endmodule // port_pin_mode_and_alt_func_tb_top
`default_nettype wire
